// ===== rtl/dmi_defines.vh
// Constants for the data-move instruction unit: opcode patterns,
// field positions, quarter-cycle codes and reset values.
// Assumes inclusion by bare name from the design files only.
`ifndef DMI_DEFINES_VH
`define DMI_DEFINES_VH

// ----------------------------------------
// Instruction word fields
// ----------------------------------------
`define DMI_NIB_HI          15:12
`define DMI_BYTE_HI         15:8
`define DMI_ADDR12          11:0
`define DMI_LIT8            7:0
`define DMI_ACC_BIT         8
`define DMI_STORE_HI        15:9

// ----------------------------------------
// Opcode patterns
// ----------------------------------------
`define DMI_OP_COPY_SRC     4'hc
`define DMI_OP_COPY_DST     4'hf
`define DMI_OP_LOAD_BANK    8'h01
`define DMI_OP_LOAD_ACC     8'h0e
`define DMI_OP_STORE        7'h37

// ----------------------------------------
// Quarter-cycle phases, one-hot
// ----------------------------------------
`define DMI_Q1              4'h1
`define DMI_Q2              4'h2
`define DMI_Q3              4'h4
`define DMI_Q4              4'h8

// ----------------------------------------
// Reset values and bank constants
// ----------------------------------------
`define DMI_ACC_RST         8'h00
`define DMI_BANK_RST        4'h0
`define DMI_BANK_NIB        3:0
`define DMI_ACCESS_LOW_HI   4'h0
`define DMI_ACCESS_HIGH_HI  4'hf
`define DMI_ACCESS_SPLIT    8'h80
`define DMI_ADDR_ZERO       12'h000
`define DMI_BYTE_ZERO       8'h00
`define DMI_WORD_ZERO       16'h0000

`endif

// ===== rtl/dmi_phase.v
// Quarter-cycle generator: rotates a one-hot Q1..Q4 phase on every clock.
// Assumes a synchronous, active-high reset from the core clock domain.
`timescale 1ns/10ps
`include "dmi_defines.vh"

module dmi_phase (
	input  wire       clock_i,
	input  wire       rst_i,
	output reg  [3:0] phase_o
);

	always @(posedge clock_i) begin
		if (rst_i) begin
			phase_o <= `DMI_Q1;
		end else begin
			phase_o <= {phase_o[2:0], phase_o[3]};
		end
	end

endmodule

// ===== rtl/dmi_move_unit.v
// Decode and execute unit for four data-move instructions of an 8-bit core.
// Assumes a program word presented at Q1 and a data space that answers a
// read in the same quarter (rd_data_i is valid in the clock where rd_en_o is high).
`timescale 1ns/10ps
`include "dmi_defines.vh"

module dmi_move_unit (
	input  wire        clock_i,
	input  wire        rst_i,
	input  wire [15:0] instr_i,
	input  wire        instr_valid_i,
	input  wire [7:0]  rd_data_i,
	output reg  [3:0]  phase_o,
	output reg         rd_en_o,
	output reg  [11:0] rd_addr_o,
	output reg         wr_en_o,
	output reg  [11:0] wr_addr_o,
	output reg  [7:0]  wr_data_o,
	output reg  [7:0]  acc_o,
	output reg  [3:0]  bank_pointer_o,
	output reg         second_word_o,
	output reg         bad_word_o
);

	// ----------------------------------------
	// State machine
	// ----------------------------------------
	localparam ST_IDLE   = 3'h1;
	localparam ST_EXEC   = 3'h2;
	localparam ST_SECOND = 3'h4;

	localparam K_NONE  = 3'h0;
	localparam K_COPY  = 3'h1;
	localparam K_BANK  = 3'h2;
	localparam K_LACC  = 3'h3;
	localparam K_STORE = 3'h4;

	wire [3:0] phase;
	reg  [2:0] state_reg;
	reg  [2:0] state_next;
	reg  [2:0] kind_reg;
	reg  [15:0] word_reg;
	reg  [7:0] data_reg;
	reg  [11:0] dst_reg;

	// ----------------------------------------
	// Quarter-cycle phase
	// ----------------------------------------
	// Live phase drives decode; phase_o is a registered copy one clock behind
	dmi_phase u_phase (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.phase_o (phase)
	);

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	// Decode one first word into an instruction kind
	function [2:0] dmi_kind;
		input [15:0] w;
		begin
			if (w[`DMI_NIB_HI] == `DMI_OP_COPY_SRC) begin
				dmi_kind = K_COPY;
			end else if (w[`DMI_BYTE_HI] == `DMI_OP_LOAD_BANK) begin
				dmi_kind = K_BANK;
			end else if (w[`DMI_BYTE_HI] == `DMI_OP_LOAD_ACC) begin
				dmi_kind = K_LACC;
			end else if (w[`DMI_STORE_HI] == `DMI_OP_STORE) begin
				dmi_kind = K_STORE;
			end else begin
				dmi_kind = K_NONE;
			end
		end
	endfunction

	// Forms the 12-bit store address from access bit, bank and offset
	function [11:0] dmi_bank_addr;
		input [15:0] w;
		input [3:0]  bank;
		begin
			if (w[`DMI_ACC_BIT]) begin
				dmi_bank_addr = {bank, w[`DMI_LIT8]};
			// Access bank: low offsets from page 0, high offsets from top page
			end else if (w[`DMI_LIT8] < `DMI_ACCESS_SPLIT) begin
				dmi_bank_addr = {`DMI_ACCESS_LOW_HI, w[`DMI_LIT8]};
			end else begin
				dmi_bank_addr = {`DMI_ACCESS_HIGH_HI, w[`DMI_LIT8]};
			end
		end
	endfunction

	// ----------------------------------------
	// Sequencing
	// ----------------------------------------
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (phase == `DMI_Q1 && instr_valid_i) begin
					state_next = ST_EXEC;
				end
			end
			ST_EXEC: begin
				if (phase == `DMI_Q4) begin
					state_next = (kind_reg == K_COPY) ? ST_SECOND : ST_IDLE;
				end
			end
			ST_SECOND: begin
				if (phase == `DMI_Q4) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// Execute
	// ----------------------------------------
	// Pulses fall back to low every clock, so no strobe can be left
	// standing if a decode is cut short
	always @(posedge clock_i) begin
		if (rst_i) begin
			state_reg      <= ST_IDLE;
			kind_reg       <= K_NONE;
			word_reg       <= `DMI_WORD_ZERO;
			data_reg       <= `DMI_BYTE_ZERO;
			dst_reg        <= `DMI_ADDR_ZERO;
			phase_o        <= `DMI_Q1;
			rd_en_o        <= 1'b0;
			rd_addr_o      <= `DMI_ADDR_ZERO;
			wr_en_o        <= 1'b0;
			wr_addr_o      <= `DMI_ADDR_ZERO;
			wr_data_o      <= `DMI_BYTE_ZERO;
			acc_o          <= `DMI_ACC_RST;
			bank_pointer_o <= `DMI_BANK_RST;
			second_word_o  <= 1'b0;
			bad_word_o     <= 1'b0;
		end else begin
			state_reg     <= state_next;
			phase_o       <= phase;
			rd_en_o       <= 1'b0;
			wr_en_o       <= 1'b0;
			bad_word_o    <= 1'b0;
			second_word_o <= 1'b0;
			if (state_reg == ST_IDLE && phase == `DMI_Q1 && instr_valid_i) begin
				word_reg <= instr_i;
				kind_reg <= dmi_kind(instr_i);
			end
			if (state_reg == ST_SECOND && phase == `DMI_Q1) begin
				second_word_o <= 1'b1;
				if (instr_i[`DMI_NIB_HI] == `DMI_OP_COPY_DST) begin
					dst_reg <= instr_i[`DMI_ADDR12];
				end else begin
					// Write still goes ahead; the flag only reports the bad pair
					bad_word_o <= 1'b1;
					dst_reg    <= instr_i[`DMI_ADDR12];
				end
			end
			if (state_reg == ST_EXEC && phase == `DMI_Q2 && kind_reg == K_COPY) begin
				rd_en_o   <= 1'b1;
				rd_addr_o <= word_reg[`DMI_ADDR12];
			end
			if (state_reg == ST_EXEC && phase == `DMI_Q3 && kind_reg == K_COPY) begin
				data_reg <= rd_data_i;
			end
			if (state_reg == ST_EXEC && phase == `DMI_Q4) begin
				case (kind_reg)
					K_BANK: begin
						bank_pointer_o <= word_reg[`DMI_BANK_NIB];
					end
					K_LACC: begin
						acc_o <= word_reg[`DMI_LIT8];
					end
					K_STORE: begin
						wr_en_o   <= 1'b1;
						wr_addr_o <= dmi_bank_addr(word_reg, bank_pointer_o);
						wr_data_o <= acc_o;
					end
					default: begin
						wr_en_o <= 1'b0;
					end
				endcase
			end
			// destination written second Q4, no dummy read
			if (state_reg == ST_SECOND && phase == `DMI_Q4) begin
				wr_en_o   <= 1'b1;
				wr_addr_o <= dst_reg;
				wr_data_o <= data_reg;
			end
		end
	end

endmodule

// ===== sim/dmi_move_unit_checker.sv
// Checker for the data-move unit: phase, read and write timing.
// Assumes a bind onto dmi_move_unit; sees its ports only.
`timescale 1ns/10ps
module dmi_move_unit_checker (
	input wire logic       clock_i,
	input wire logic       rst_i,
	input wire logic [3:0] phase_o,
	input wire logic       rd_en_o,
	input wire logic       wr_en_o,
	input wire logic [7:0] acc_o,
	input wire logic [3:0] bank_pointer_o,
	input wire logic       second_word_o,
	input wire logic       bad_word_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	// --------
	// Properties
	// --------
	a_phase_rotate: assert property (
		phase_o inside {4'h2, 4'h4, 4'h8} |=> phase_o == {$past(phase_o[2:0]), $past(phase_o[3])})
		else $error("phase out of order");
	a_read_in_q2: assert property (
		rd_en_o |-> phase_o == 4'h2) else $error("read outside Q2");
	a_no_dummy_read: assert property (
		rd_en_o |=> !rd_en_o [*7]) else $error("extra read in copy");
	a_copy_write_time: assert property (
		rd_en_o |-> ##6 wr_en_o) else $error("copy write late");
	a_second_word_time: assert property (
		rd_en_o |-> ##3 second_word_o) else $error("second word missed");
	a_write_in_q4: assert property (
		wr_en_o |-> phase_o == 4'h8) else $error("write outside Q4");
	a_acc_in_q4: assert property (
		$changed(acc_o) |-> phase_o == 4'h8) else $error("acc changed outside Q4");
	a_bank_in_q4: assert property (
		$changed(bank_pointer_o) |-> phase_o == 4'h8) else $error("bank changed outside Q4");
	cover property (second_word_o && !bad_word_o);
	cover property (bad_word_o);
	cover property (wr_en_o && !second_word_o);
endmodule

bind dmi_move_unit dmi_move_unit_checker u_chk (.clock_i, .rst_i, .phase_o, .rd_en_o,
	.wr_en_o, .acc_o, .bank_pointer_o, .second_word_o, .bad_word_o);

// ===== sim/test_data_move_instructions.sv
// Testbench for the data-move unit: drives program words and read data.
// Assumes a first word is taken at internal Q1, seen as phase_o Q4.
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
	$display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
module test_data_move_instructions;
	logic        clock_i = 0, rst_i = 1, instr_valid_i = 0;
	logic [15:0] instr_i = 16'h0000;
	logic [7:0]  rd_data_i = 8'h00, acc_m = 8'h00;
	logic [3:0]  bank_m = 4'h0;
	wire  [3:0]  phase_o, bank_pointer_o;
	wire         rd_en_o, wr_en_o, second_word_o, bad_word_o;
	wire  [11:0] rd_addr_o, wr_addr_o;
	wire  [7:0]  wr_data_o, acc_o;
	int          err_count = 0, n_tests = 0;

	always #20 clock_i = ~clock_i;
	dmi_move_unit DUT (.clock_i, .rst_i, .instr_i, .instr_valid_i, .rd_data_i, .phase_o,
		.rd_en_o, .rd_addr_o, .wr_en_o, .wr_addr_o, .wr_data_o, .acc_o, .bank_pointer_o,
		.second_word_o, .bad_word_o);
	// --------
	// Tasks
	// --------
	task automatic step(input int n);
		repeat (n) @(negedge clock_i);
	endtask
	// Ends one cycle after the Q1 that took the word
	task automatic issue(input logic [15:0] w);
		repeat (8) if (phase_o !== 4'h8) step(1);
		instr_i = w;
		instr_valid_i = 1;
		step(1);
		instr_valid_i = 0;
		`CHK(phase_o, 4'h1)
	endtask
	task automatic t_load_acc(input logic [7:0] k);
		issue({8'h0e, k});
		step(2);
		`CHK(acc_o, acc_m)
		step(1);
		acc_m = k;
		`CHK(acc_o, k)
	endtask
	task automatic t_load_bank(input logic [7:0] k);
		issue({8'h01, k});
		step(3);
		bank_m = k[3:0];
		`CHK(bank_pointer_o, bank_m)
	endtask
	task automatic t_store(input logic a, input logic [7:0] f);
		logic [11:0] ea;
		ea = a ? {bank_m, f} : {(f < 8'h80) ? 4'h0 : 4'hf, f};
		issue({7'b0110111, a, f});
		step(2);
		`CHK(wr_en_o, 1'b0)
		step(1);
		`CHK(wr_en_o, 1'b1)
		`CHK(wr_addr_o, ea)
		`CHK(wr_data_o, acc_m)
	endtask
	task automatic t_copy(input logic [11:0] s, d, input logic [7:0] b, input logic [3:0] hn);
		issue({4'b1100, s});
		step(1);
		`CHK(rd_en_o, 1'b1)
		`CHK(rd_addr_o, s)
		rd_data_i = b;
		step(1);
		rd_data_i = ~b;
		step(1);
		instr_i = {hn, d};
		step(1);
		instr_i = ~instr_i;
		`CHK(second_word_o, 1'b1)
		`CHK(bad_word_o, hn !== 4'hf)
		`CHK(wr_en_o, 1'b0)
		step(3);
		`CHK(wr_en_o, 1'b1)
		`CHK(wr_addr_o, d)
		`CHK(wr_data_o, b)
	endtask
	task automatic t_none;
		issue(16'h0000);
		step(3);
		`CHK(wr_en_o, 1'b0)
		`CHK(acc_o, acc_m)
		`CHK(bank_pointer_o, bank_m)
	endtask
	task automatic t_reset;
		rst_i = 1;
		step(3);
		`CHK(acc_o, 8'h00)
		`CHK(bank_pointer_o, 4'h0)
		`CHK(wr_en_o, 1'b0)
		`CHK(phase_o, 4'h1)
		rst_i = 0;
		acc_m = 8'h00;
		bank_m = 4'h0;
	endtask
	task automatic final_report;
		if (err_count == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// --------
	// Sequence
	// --------
	initial begin
		step(3);
		rst_i = 0;
		t_load_acc(8'h5a);
		t_load_acc(8'hff);
		t_load_acc(8'h00);
		t_load_acc(8'hc3);
		t_load_bank(8'hf7);
		t_store(1'b1, 8'h05);
		t_store(1'b1, 8'hff);
		t_store(1'b0, 8'h7f);
		t_store(1'b0, 8'h80);
		t_copy(12'h123, 12'h456, 8'h33, 4'hf);
		t_copy(12'hfff, 12'h000, 8'ha5, 4'hf);
		t_copy(12'h000, 12'hfff, 8'h5c, 4'h3);
		t_none();
		t_reset();
		t_store(1'b1, 8'h10);
		t_load_acc(8'h3c);
		final_report();
	end
	// About 90 cycles are needed; allow 1000
	initial begin
		#40000;
		err_count++;
		final_report();
	end
endmodule
